//--- digital_io_port_bank.sv
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_bank_params.svh"
module digital_io_port_bank
  import gpio_bank_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic global_irq_enable,
  input wire logic [`PIN_COUNT-1:0] pin_level,
  output logic [`PIN_COUNT-1:0] pin_drive,
  output logic [`PIN_COUNT-1:0] pin_drive_en,
  output logic [`PIN_COUNT-1:0] pull_up_en,
  output logic [`PIN_COUNT-1:0] pull_down_en,
  input wire logic [`PIN_COUNT-1:0] periph_out_value,
  output logic [`PIN_COUNT-1:0] periph_in_value,
  output logic irq_port_one,
  output logic irq_port_two
);

  state_s st;
  state_s next_st;
  decode_s dec;
  pins_t edge_hit;
  irq_pins_t hw_set;
  irq_pins_t ies_set;
  irq_pins_t new_ies;

  // address to register kind and port index
  function automatic decode_s decode(input logic [7:0] a);
    decode_s d;
    d.kind = K_NONE;
    d.port = 3'd0;
    // flags and edge select exist only on the first two ports
    case (a)
      `PORT_ONE_IN:
      begin
        d.kind = K_IN;
        d.port = 3'd0;
      end
      `PORT_ONE_OUT:
      begin
        d.kind = K_OUT;
        d.port = 3'd0;
      end
      `PORT_ONE_DIR:
      begin
        d.kind = K_DIR;
        d.port = 3'd0;
      end
      `PORT_ONE_IFG:
      begin
        d.kind = K_IFG;
        d.port = 3'd0;
      end
      `PORT_ONE_IES:
      begin
        d.kind = K_IES;
        d.port = 3'd0;
      end
      `PORT_ONE_IE:
      begin
        d.kind = K_IE;
        d.port = 3'd0;
      end
      `PORT_ONE_SEL:
      begin
        d.kind = K_SEL;
        d.port = 3'd0;
      end
      `PORT_ONE_REN:
      begin
        d.kind = K_REN;
        d.port = 3'd0;
      end
      `PORT_TWO_IN:
      begin
        d.kind = K_IN;
        d.port = 3'd1;
      end
      `PORT_TWO_OUT:
      begin
        d.kind = K_OUT;
        d.port = 3'd1;
      end
      `PORT_TWO_DIR:
      begin
        d.kind = K_DIR;
        d.port = 3'd1;
      end
      `PORT_TWO_IFG:
      begin
        d.kind = K_IFG;
        d.port = 3'd1;
      end
      `PORT_TWO_IES:
      begin
        d.kind = K_IES;
        d.port = 3'd1;
      end
      `PORT_TWO_IE:
      begin
        d.kind = K_IE;
        d.port = 3'd1;
      end
      `PORT_TWO_SEL:
      begin
        d.kind = K_SEL;
        d.port = 3'd1;
      end
      `PORT_TWO_REN:
      begin
        d.kind = K_REN;
        d.port = 3'd1;
      end
      `P3_IN:
      begin
        d.kind = K_IN;
        d.port = 3'd2;
      end
      `P3_OUT:
      begin
        d.kind = K_OUT;
        d.port = 3'd2;
      end
      `P3_DIR:
      begin
        d.kind = K_DIR;
        d.port = 3'd2;
      end
      `P3_SEL:
      begin
        d.kind = K_SEL;
        d.port = 3'd2;
      end
      `P3_REN:
      begin
        d.kind = K_REN;
        d.port = 3'd2;
      end
      `P4_IN:
      begin
        d.kind = K_IN;
        d.port = 3'd3;
      end
      `P4_OUT:
      begin
        d.kind = K_OUT;
        d.port = 3'd3;
      end
      `P4_DIR:
      begin
        d.kind = K_DIR;
        d.port = 3'd3;
      end
      `P4_SEL:
      begin
        d.kind = K_SEL;
        d.port = 3'd3;
      end
      `P4_REN:
      begin
        d.kind = K_REN;
        d.port = 3'd3;
      end
      `P5_IN:
      begin
        d.kind = K_IN;
        d.port = 3'd4;
      end
      `P5_OUT:
      begin
        d.kind = K_OUT;
        d.port = 3'd4;
      end
      `P5_DIR:
      begin
        d.kind = K_DIR;
        d.port = 3'd4;
      end
      `P5_SEL:
      begin
        d.kind = K_SEL;
        d.port = 3'd4;
      end
      `P5_REN:
      begin
        d.kind = K_REN;
        d.port = 3'd4;
      end
      `P6_IN:
      begin
        d.kind = K_IN;
        d.port = 3'd5;
      end
      `P6_OUT:
      begin
        d.kind = K_OUT;
        d.port = 3'd5;
      end
      `P6_DIR:
      begin
        d.kind = K_DIR;
        d.port = 3'd5;
      end
      `P6_SEL:
      begin
        d.kind = K_SEL;
        d.port = 3'd5;
      end
      `P6_REN:
      begin
        d.kind = K_REN;
        d.port = 3'd5;
      end
      // unmapped: write ignored, read gives zero
      default:
      begin
        d.kind = K_NONE;
        d.port = 3'd0;
      end
    endcase
    return d;
  endfunction : decode

  // one process computes every next value
  always_comb
  begin
    next_st = st;
    dec = decode(addr);
    new_ies = st.ies;
    // three-stage synchroniser; stage one feeds stage two only
    next_st.sync1 = pin_level;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    // a change counts once stages two and three agree
    for (int i = 0; i < `PIN_COUNT; i++)
    begin
      if (st.sync2[i] == st.sync3[i])
      begin
        next_st.level[i] = st.sync3[i];
      end
    end
    next_st.prev = st.level;
    // transitions only, never static levels
    for (int i = 0; i < `PIN_COUNT; i++)
    begin
      edge_hit[i] = st.level[i] ^ st.prev[i];
    end
    for (int i = 0; i < `IRQ_PIN_COUNT; i++)
    begin
      // 0 arms rising, 1 arms falling; selected pins are silent
      hw_set[i] = edge_hit[i] & (st.level[i] ^ st.ies[i]) & ~st.sel[i];
    end
    // register writes; input registers have no write effect
    if (wr_en)
    begin
      case (dec.kind)
        K_OUT: next_st.out[dec.port*8 +: 8] = wr_data;
        K_DIR: next_st.dir[dec.port*8 +: 8] = wr_data;
        K_SEL: next_st.sel[dec.port*8 +: 8] = wr_data;
        K_REN: next_st.ren[dec.port*8 +: 8] = wr_data;
        K_IFG: next_st.ifg[dec.port*8 +: 8] = wr_data;
        K_IES: new_ies[dec.port*8 +: 8] = wr_data;
        K_IE: next_st.ie[dec.port*8 +: 8] = wr_data;
        K_IN: next_st.out = st.out;
        default: next_st.out = next_st.out;
      endcase
    end
    next_st.ies = new_ies;
    // new edge sense that differs from the pin level raises the flag
    for (int i = 0; i < `IRQ_PIN_COUNT; i++)
    begin
      ies_set[i] = (new_ies[i] ^ st.ies[i]) & (st.level[i] ^ new_ies[i]) & ~st.sel[i];
    end
    // hardware set wins over a same-cycle software clear
    next_st.ifg = next_st.ifg | hw_set | ies_set;
    // one request line for each of ports one and two, both enables needed
    next_st.irq[0] = global_irq_enable & |(st.ifg[7:0] & st.ie[7:0]);
    next_st.irq[1] = global_irq_enable & |(st.ifg[15:8] & st.ie[15:8]);
    // pad control; pull resistor overrides port output drive
    for (int i = 0; i < `PIN_COUNT; i++)
    begin
      next_st.drive_en[i] = st.dir[i] & (st.sel[i] | ~st.ren[i]);
      next_st.drive[i] = st.sel[i] ? periph_out_value[i] : st.out[i];
      next_st.pull_up[i] = st.ren[i] & ~next_st.drive_en[i] & st.out[i];
      next_st.pull_down[i] = st.ren[i] & ~next_st.drive_en[i] & ~st.out[i];
      // transparent while selected, frozen after deselect
      if (st.sel[i])
      begin
        next_st.latch[i] = st.level[i];
      end
    end
    // read data valid the cycle after the strobe only
    next_st.rd_data = 8'h00;
    if (rd_en)
    begin
      case (dec.kind)
        K_IN: next_st.rd_data = st.level[dec.port*8 +: 8];
        K_OUT: next_st.rd_data = st.out[dec.port*8 +: 8];
        K_DIR: next_st.rd_data = st.dir[dec.port*8 +: 8];
        K_SEL: next_st.rd_data = st.sel[dec.port*8 +: 8];
        K_REN: next_st.rd_data = st.ren[dec.port*8 +: 8];
        K_IFG: next_st.rd_data = st.ifg[dec.port*8 +: 8];
        K_IES: next_st.rd_data = st.ies[dec.port*8 +: 8];
        K_IE: next_st.rd_data = st.ie[dec.port*8 +: 8];
        default: next_st.rd_data = 8'h00;
      endcase
    end
  end

  // state register; synchronous active-low reset
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      st <= '0;
      st.sel <= `SEL_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // every output straight from the state register
  assign rd_data = st.rd_data;
  assign pin_drive = st.drive;
  assign pin_drive_en = st.drive_en;
  assign pull_up_en = st.pull_up;
  assign pull_down_en = st.pull_down;
  assign periph_in_value = st.latch;
  assign irq_port_one = st.irq[0];
  assign irq_port_two = st.irq[1];
endmodule : digital_io_port_bank
`default_nettype wire

//--- digital_io_port_bank_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpio_bank_params.svh"
module digital_io_port_bank_tb import gpio_bank_pkg::*;;
  logic ref_clk = '0, rst_b = '0, wr_en = '0, rd_en = '0, global_irq_enable = '0;
  logic [7:0] addr = '0, wr_data = '0, rd_data, v, s;
  pins_t ext = '0, per_o = '0, pin_level, pin_drive, pin_drive_en, pull_up_en, pull_down_en, pi;
  logic irq_port_one, irq_port_two;
  int fails = 0, n_checks = 0, cyc = 0;
  logic [7:0] da [6] = '{`PORT_ONE_DIR, `PORT_TWO_DIR, `P3_DIR, `P4_DIR, `P5_DIR, `P6_DIR};
  digital_io_port_bank i_digital_io_port_bank (.ref_clk, .rst_b, .addr, .wr_data, .wr_en, .rd_en,
    .rd_data, .global_irq_enable, .pin_level, .pin_drive, .pin_drive_en, .pull_up_en,
    .pull_down_en, .periph_out_value(per_o), .periph_in_value(pi), .irq_port_one, .irq_port_two);
  dio_pins_model i_dio_pins_model (.pin_drive, .pin_drive_en, .pull_up_en, .pull_down_en,
    .ext_level(ext), .pin_level);
  // 25 MHz clock
  initial forever #20 ref_clk = ~ref_clk;
  task automatic t(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : t
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  // strobes last one cycle, a gap keeps each edge to one assignment
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    t(1);
    addr <= a;
    wr_data <= d;
    wr_en <= '1;
    t(1);
    wr_en <= '0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    t(1);
    addr <= a;
    rd_en <= '1;
    t(1);
    rd_en <= '0;
    #1 chk(rd_data, e);
  endtask : rc
  task automatic print_verdict;
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // hang guard, tests need about 260 cycles
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      fails++;
      print_verdict();
    end
  end
  initial
  begin
    void'($urandom(99));
    ext <= {16'($urandom), $urandom};
    per_o <= {16'($urandom), $urandom};
    t(5);
    rst_b <= '1;
    rc(`PORT_TWO_SEL, 8'hC0);
    rc(8'h00, 8'h00);
    // each port drives, ignores input writes, then reads outside levels
    foreach (da[p])
    begin
      v = 8'($urandom);
      s = (p == 1) ? 8'hC0 : 8'h00;
      wr(da[p], 8'hFF);
      wr(da[p] - 8'h01, v);
      wr(da[p] - 8'h02, ~v);
      t(5);
      chk(pin_drive[p*8+:8], (v & ~s) | (per_o[p*8+:8] & s));
      chk(pin_drive_en[p*8+:8], 8'hFF);
      rc(da[p] - 8'h01, v);
      rc(da[p] - 8'h02, (v & ~s) | (per_o[p*8+:8] & s));
      wr(da[p], 8'h00);
      t(5);
      rc(da[p] - 8'h02, ext[p*8+:8]);
    end
    // pulls on port one follow the output bits
    wr(`PORT_ONE_REN, 8'hFF);
    wr(`PORT_ONE_OUT, 8'h5A);
    t(5);
    chk(pull_up_en[7:0], 8'h5A);
    chk(pull_down_en[7:0], 8'hA5);
    rc(`PORT_ONE_IN, 8'h5A);
    wr(`PORT_ONE_REN, 8'h00);
    // peripheral input tracks, then holds once deselected
    wr(`P3_SEL, 8'hFF);
    t(6);
    chk(pi[23:16], ext[23:16]);
    rc(`P3_DIR, 8'h00);
    v = ext[23:16];
    wr(`P3_SEL, 8'h00);
    ext <= ~ext;
    t(6);
    chk(pi[23:16], v);
    // edge flags on port one, software flag on port two
    global_irq_enable <= '1;
    ext[8:0] <= '0;
    t(6);
    wr(`PORT_ONE_IFG, 8'h00);
    wr(`PORT_TWO_IFG, 8'h00);
    wr(`PORT_ONE_IE, 8'h01);
    wr(`PORT_TWO_IE, 8'h01);
    ext[0] <= '1;
    t(7);
    chk(8'(irq_port_one), 8'h01);
    chk(8'(irq_port_two), 8'h00);
    rc(`PORT_ONE_IFG, 8'h01);
    global_irq_enable <= '0;
    t(2);
    chk(8'(irq_port_one), 8'h00);
    global_irq_enable <= '1;
    wr(`PORT_ONE_IFG, 8'h00);
    wr(`PORT_ONE_IES, 8'h01);
    wr(`PORT_ONE_SEL, 8'h01);
    ext[0] <= '0;
    wr(`PORT_TWO_IFG, 8'h01);
    t(6);
    chk(8'(irq_port_one), 8'h00);
    chk(8'(irq_port_two), 8'h01);
    wr(`PORT_ONE_SEL, 8'h00);
    ext[0] <= '1;
    t(7);
    ext[0] <= '0;
    t(7);
    rc(`PORT_ONE_IFG, 8'h01);
    // rising edge while falling is armed sets nothing
    wr(`PORT_ONE_IFG, 8'h00);
    ext[0] <= '1;
    t(7);
    rc(`PORT_ONE_IFG, 8'h00);
    // edge sense 1 to 0 with the pin high raises the flag
    wr(`PORT_ONE_IES, 8'h00);
    t(1);
    rc(`PORT_ONE_IFG, 8'h01);
    print_verdict();
  end
endmodule : digital_io_port_bank_tb
bind digital_io_port_bank dio_bank_chk i_dio_bank_chk (.ref_clk, .rst_b, .addr, .wr_en, .rd_en,
  .rd_data, .global_irq_enable, .pin_drive_en, .pull_up_en, .pull_down_en, .irq_port_one,
  .irq_port_two);
`default_nettype wire

//--- dio_bank_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpio_bank_params.svh"
module dio_bank_chk
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic global_irq_enable,
  input wire logic [`PIN_COUNT-1:0] pin_drive_en,
  input wire logic [`PIN_COUNT-1:0] pull_up_en,
  input wire logic [`PIN_COUNT-1:0] pull_down_en,
  input wire logic irq_port_one,
  input wire logic irq_port_two
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // bus answers, pads, interrupt gating
  property p_rdz; !rd_en |=> rd_data == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("stray read data");
  property p_unm; rd_en && addr == 8'h00 |=> rd_data == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_pex; (pull_up_en & pull_down_en) == '0; endproperty
  a_pex: assert property (p_pex) else $error("both pulls");
  property p_pdr; ((pull_up_en | pull_down_en) & pin_drive_en) == '0; endproperty
  a_pdr: assert property (p_pdr) else $error("pull while driving");
  property p_g1; !global_irq_enable |=> !irq_port_one; endproperty
  a_g1: assert property (p_g1) else $error("irq one ungated");
  property p_g2; !global_irq_enable |=> !irq_port_two; endproperty
  a_g2: assert property (p_g2) else $error("irq two ungated");
  // a write one edge back may still clear the flag or enable behind the line
  property p_s1;
    irq_port_one && global_irq_enable && !wr_en && !$past(wr_en) |=> irq_port_one;
  endproperty
  a_s1: assert property (p_s1) else $error("irq one dropped");
  property p_s2;
    irq_port_two && global_irq_enable && !wr_en && !$past(wr_en) |=> irq_port_two;
  endproperty
  a_s2: assert property (p_s2) else $error("irq two dropped");
endmodule : dio_bank_chk
`default_nettype wire

//--- dio_pins_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpio_bank_params.svh"
module dio_pins_model
(
  input wire logic [`PIN_COUNT-1:0] pin_drive,
  input wire logic [`PIN_COUNT-1:0] pin_drive_en,
  input wire logic [`PIN_COUNT-1:0] pull_up_en,
  input wire logic [`PIN_COUNT-1:0] pull_down_en,
  input wire logic [`PIN_COUNT-1:0] ext_level,
  output logic [`PIN_COUNT-1:0] pin_level
);
  // block driver wins, then a pull, then the outside device
  assign pin_level = (pin_drive_en & pin_drive)
    | (~pin_drive_en & (pull_up_en | (~pull_down_en & ext_level)));
endmodule : dio_pins_model
`default_nettype wire

//--- gpio_bank_params.svh
`ifndef GPIO_BANK_PARAMS_SVH
`define GPIO_BANK_PARAMS_SVH
`define PORT_COUNT 6
`define PORT_WIDTH 8
`define PIN_COUNT 48
`define IRQ_PIN_COUNT 16
`define PORT_ONE_IN 8'h20
`define PORT_ONE_OUT 8'h21
`define PORT_ONE_DIR 8'h22
`define PORT_ONE_IFG 8'h23
`define PORT_ONE_IES 8'h24
`define PORT_ONE_IE 8'h25
`define PORT_ONE_SEL 8'h26
`define PORT_ONE_REN 8'h27
`define PORT_TWO_IN 8'h28
`define PORT_TWO_OUT 8'h29
`define PORT_TWO_DIR 8'h2A
`define PORT_TWO_IFG 8'h2B
`define PORT_TWO_IES 8'h2C
`define PORT_TWO_IE 8'h2D
`define PORT_TWO_SEL 8'h2E
`define PORT_TWO_REN 8'h2F
`define P3_IN 8'h18
`define P3_OUT 8'h19
`define P3_DIR 8'h1A
`define P3_SEL 8'h1B
`define P3_REN 8'h10
`define P4_IN 8'h1C
`define P4_OUT 8'h1D
`define P4_DIR 8'h1E
`define P4_SEL 8'h1F
`define P4_REN 8'h11
`define P5_IN 8'h30
`define P5_OUT 8'h31
`define P5_DIR 8'h32
`define P5_SEL 8'h33
`define P5_REN 8'h12
`define P6_IN 8'h34
`define P6_OUT 8'h35
`define P6_DIR 8'h36
`define P6_SEL 8'h37
`define P6_REN 8'h13
`define SEL_RESET 48'h0000_0000_C000
`define ZERO_RESET 48'h0000_0000_0000
`endif

//--- gpio_bank_pkg.sv
`include "gpio_bank_params.svh"
package gpio_bank_pkg;
  typedef enum logic [3:0] {
    K_NONE = 4'b0000,
    K_IN = 4'b0001,
    K_OUT = 4'b0010,
    K_DIR = 4'b0011,
    K_IFG = 4'b0100,
    K_IES = 4'b0101,
    K_IE = 4'b0110,
    K_SEL = 4'b0111,
    K_REN = 4'b1000
  } reg_kind_e;

  typedef struct packed {
    reg_kind_e kind;
    logic [2:0] port;
  } decode_s;

  typedef logic [`PIN_COUNT-1:0] pins_t;
  typedef logic [`IRQ_PIN_COUNT-1:0] irq_pins_t;

  typedef struct packed {
    pins_t sync1;
    pins_t sync2;
    pins_t sync3;
    pins_t level;
    pins_t prev;
    pins_t out;
    pins_t dir;
    pins_t sel;
    pins_t ren;
    pins_t latch;
    pins_t drive;
    pins_t drive_en;
    pins_t pull_up;
    pins_t pull_down;
    irq_pins_t ifg;
    irq_pins_t ies;
    irq_pins_t ie;
    logic [7:0] rd_data;
    logic [1:0] irq;
  } state_s;
endpackage : gpio_bank_pkg
